// ### logic/sies_regs.svh
// Register indexes, field values and fixed addresses of the sequencer
`ifndef SIES_REGS_SVH
`define SIES_REGS_SVH
// Word indexes on the register bus (byte address is four times these)
`define SIES_REG_CTRL 5'h00
`define SIES_REG_STATUS 5'h01
`define SIES_REG_PC 5'h02
`define SIES_REG_SP 5'h03
`define SIES_REG_FRAME 5'h04
`define SIES_REG_SLIMIT 5'h05
`define SIES_REG_DBASE 5'h06
`define SIES_REG_DLIMIT 5'h07
`define SIES_REG_CBASE 5'h08
`define SIES_REG_CLIMIT 5'h09
`define SIES_REG_CBANK 5'h0A
`define SIES_REG_DBANK 5'h0B
`define SIES_REG_SBANK 5'h0C
`define SIES_REG_INDEX 5'h0D
`define SIES_REG_TOSN 5'h0E
`define SIES_REG_TOS0 5'h10
`define SIES_REG_DEV 5'h14
// Control register fields
`define SIES_CTRL_RET_BIT 0
`define SIES_CTRL_ICS_BIT 1
`define SIES_CTRL_SCHED_BIT 2
`define SIES_CTRL_SCHED_CLR_BIT 3
// Status word values and fields
`define SIES_STAT_INT 16'h8001
`define SIES_STAT_EXT 16'hC000
`define SIES_STAT_EXT_EN_BIT 14
`define SIES_RST_WORD 16'h0000
// Fixed memory words and table layout
`define SIES_QI_ADDR 16'h0005
`define SIES_ZI_ADDR 16'h0006
`define SIES_DL_ICS 16'hFFFF
`define SIES_DRT_BASE 16'h0400
`define SIES_CST_BASE 16'h0800
`define SIES_DRT_LBL 16'h0001
`define SIES_DRT_DBI 16'h0002
`define SIES_INT_SEG 8'h01
// Marker layout
`define SIES_MARK_STD 3'h4
`define SIES_MARK_ICS 3'h6
`define SIES_LINK_IDX 3'h3
`define SIES_CST_LAST 3'h2
`define SIES_DISP_BIT 16'h8000
`define SIES_PARAM_OFF 16'h0003
`define SIES_USRDB_OFF 16'h0004
`define SIES_USRS_OFF 16'h0006
`define SIES_RET_P_OFF 16'h0002
`define SIES_TOS_DEPTH 4
`endif

// ### logic/sies_pkg.sv
// Types shared by the interrupt entry sequencer
package sies_pkg;
   typedef enum logic [4:0] {
      SIES_IDLE  = 5'h00,
      SIES_FLUSH = 5'h01,
      SIES_MARK  = 5'h03,
      SIES_LDQI  = 5'h02,
      SIES_LDZI  = 5'h06,
      SIES_RDQ4  = 5'h07,
      SIES_WRQ6  = 5'h05,
      SIES_RDDBI = 5'h04,
      SIES_WRDEV = 5'h0C,
      SIES_RDLBL = 5'h0D,
      SIES_RDCST = 5'h0F,
      SIES_RDSTT = 5'h0E,
      SIES_FETCH = 5'h0A,
      SIES_RTDEV = 5'h0B,
      SIES_RTLNK = 5'h09,
      SIES_RTP   = 5'h08
   } sies_state_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [7:0] bank;
      logic [15:0] addr;
      logic [15:0] wdata;
   } sies_mem_req_t;
endpackage

// ### logic/sies_seq.sv
// Interrupt entry and return sequencer with its register slave
`timescale 1ns/100ps
`include "sies_regs.svh"

// Overview of operation
// - Stack-switching internal entry saves user state, moves to interrupt stack.
// - Non-switching internal entry runs on the user stack after saving state.
// - Internal entries load code base and limit from code table entry 1.
// - Internal entry writes status as privileged, segment 1, value 8001 hex.
// - Internal entry loads the program counter through the transfer table.
// - Highest priority external first; higher ones may preempt lower handling.
// - Priority comes only from poll-chain position, never from device number.
// - First-level entry flushes stack cache, pushes marker, data bank, base.
// - Stack bank is cleared, interrupt stack lives in bank 0.
// - Frame origin from word 5, stack limit from word 6, stack flag set.
// - First-level entry sets data limit to all ones.
// - First level stores user stack pointer minus saved base at origin-6.
// - Device number from processor, table entry computed, base from third word.
// - First-level entry sets status C000 hex and clears data bank.
// - Stack pointer becomes frame plus 3, device number written there.
// - First level loads code bank, base, limit from segment entry in order.
// - Receiver address from transfer table, segment into status, fetch begins.
// - Nested entry flushes cache, pushes six-word marker, no stack switch.
// - Nested frame pointer moves to new link word holding distance back.
// - Nested entries never write the stack pointer at frame minus six.
// - Return restores address, frame, stack pointer, sends reset command.
// - Scheduler interrupted takes nested path, marks link bit 15, clears flag.
module sies_seq
   import sies_pkg::*;
#(
   parameter int TOS_DEPTH = `SIES_TOS_DEPTH,
   parameter logic [15:0] DRT_BASE = `SIES_DRT_BASE,
   parameter logic [15:0] CST_BASE = `SIES_CST_BASE
)(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // Register slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Memory access
   output sies_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // Internal interrupt source
   input wire logic int_req,
   input wire logic int_ics,
   input wire logic [7:0] int_stt,
   output logic int_ack,
   // I/O processor side
   input wire logic ext_req,
   input wire logic [7:0] ext_dev,
   output logic ext_ack,
   output logic rst_cmd,
   output logic [7:0] rst_dev,
   // Receiver start
   output logic fetch_done,
   output logic [15:0] fetch_instr
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   sies_state_t st;
   logic [2:0] cnt;
   logic ext_f, first_f, ics_int, nest_sched;
   logic [15:0] label, drt_addr, tmp, user_s;
   logic [7:0] dev;
   logic [15:0] status, pc, sp, fq, fz, dbr, dlr, cbase, clim, xr;
   logic [7:0] cbank, dbank, sbank;
   logic [2:0] tos_n;
   logic [15:0] top_stack_cache [TOS_DEPTH];
   logic ics_flag, sched_flag, ret_pend;
   logic go_int, go_ext, go_ret, any_go, bus_wr;
   logic [2:0] mark_len;
   logic [15:0] mark_word;
   sies_mem_req_t next_acc;
   logic [31:0] next_rdata;

   // Table entry address, four words per entry
   function automatic logic [15:0] tbl_addr(input logic [15:0] base,
                                            input logic [7:0] idx);
      tbl_addr = base + {6'h00, idx, 2'b00};
   endfunction

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   // Internal wins over external when both arrive together
   assign go_int = int_req;
   // take the poll chain's nonzero pick while status bit 14 is set
   assign go_ext = ext_req && (ext_dev != 8'h00)
                   && status[`SIES_STAT_EXT_EN_BIT];
   assign go_ret = ret_pend;
   assign any_go = go_int | go_ext | go_ret;
   assign bus_wr = avs_write && !avs_waitrequest;
   // INTERRUPT_CONTROL_STACK-type frames carry data bank and base as words five and six
   assign mark_len = (ext_f || ics_int) ? `SIES_MARK_ICS : `SIES_MARK_STD;

   // Marker word selected by position
   always_comb begin
      unique case (cnt)
         3'h0: mark_word = xr;
         3'h1: mark_word = pc - cbase;
         3'h2: mark_word = status;
         3'h3: mark_word = ((sp + 16'h0001) - fq)
                           | (nest_sched ? `SIES_DISP_BIT : 16'h0000);
         3'h4: mark_word = {8'h00, dbank};
         default: mark_word = dbr;
      endcase
   end

   // ------------------------------------------------------------
   // Memory access for the current step
   // ------------------------------------------------------------
   always_comb begin
      next_acc = '0;
      next_acc.valid = 1'b1;
      unique case (st)
         SIES_FLUSH: begin
            next_acc.we = 1'b1;
            next_acc.bank = sbank;
            next_acc.addr = sp + 16'h0001;
            next_acc.wdata = top_stack_cache[cnt[1:0]];
         end
         SIES_MARK: begin
            next_acc.we = 1'b1;
            next_acc.bank = sbank;
            next_acc.addr = sp + 16'h0001;
            next_acc.wdata = mark_word;
         end
         SIES_LDQI: next_acc.addr = `SIES_QI_ADDR;
         SIES_LDZI: next_acc.addr = `SIES_ZI_ADDR;
         SIES_RDQ4: next_acc.addr = fq - `SIES_USRDB_OFF;
         SIES_WRQ6: begin
            next_acc.we = 1'b1;
            next_acc.addr = fq - `SIES_USRS_OFF;
            next_acc.wdata = user_s - tmp;
         end
         SIES_RDDBI: next_acc.addr = drt_addr + `SIES_DRT_DBI;
         SIES_WRDEV: begin
            next_acc.we = 1'b1;
            next_acc.addr = fq + `SIES_PARAM_OFF;
            next_acc.wdata = {8'h00, dev};
         end
         SIES_RDLBL: next_acc.addr = drt_addr + `SIES_DRT_LBL;
         SIES_RDCST: next_acc.addr = tbl_addr(CST_BASE, label[7:0])
                                     + {13'h0000, cnt};
         SIES_RDSTT: begin
            next_acc.bank = cbank;
            next_acc.addr = clim - {8'h00, label[15:8]};
         end
         SIES_FETCH: begin
            next_acc.bank = cbank;
            next_acc.addr = pc;
         end
         SIES_RTDEV: begin
            next_acc.bank = sbank;
            next_acc.addr = fq + `SIES_PARAM_OFF;
         end
         SIES_RTLNK: begin
            next_acc.bank = sbank;
            next_acc.addr = fq;
         end
         SIES_RTP: begin
            next_acc.bank = sbank;
            next_acc.addr = fq - `SIES_RET_P_OFF;
         end
         default: next_acc.valid = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   // Read mux, unused high bits read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (avs_address)
         `SIES_REG_CTRL: next_rdata = {29'h0, sched_flag, ics_flag,
                                       ret_pend};
         `SIES_REG_STATUS: next_rdata = {16'h0000, status};
         `SIES_REG_PC: next_rdata = {16'h0000, pc};
         `SIES_REG_SP: next_rdata = {16'h0000, sp};
         `SIES_REG_FRAME: next_rdata = {16'h0000, fq};
         `SIES_REG_SLIMIT: next_rdata = {16'h0000, fz};
         `SIES_REG_DBASE: next_rdata = {16'h0000, dbr};
         `SIES_REG_DLIMIT: next_rdata = {16'h0000, dlr};
         `SIES_REG_CBASE: next_rdata = {16'h0000, cbase};
         `SIES_REG_CLIMIT: next_rdata = {16'h0000, clim};
         `SIES_REG_CBANK: next_rdata = {24'h000000, cbank};
         `SIES_REG_DBANK: next_rdata = {24'h000000, dbank};
         `SIES_REG_SBANK: next_rdata = {24'h000000, sbank};
         `SIES_REG_INDEX: next_rdata = {16'h0000, xr};
         `SIES_REG_TOSN: next_rdata = {29'h0, tos_n};
         `SIES_REG_DEV: next_rdata = {24'h000000, dev};
         default: begin
            if (avs_address >= `SIES_REG_TOS0 && avs_address
                < `SIES_REG_TOS0 + 5'(TOS_DEPTH))
               next_rdata = {16'h0000,
                  top_stack_cache[2'(avs_address - `SIES_REG_TOS0)]};
         end
      endcase
   end

   // Answer only while idle, so software never races the sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         avs_waitrequest <= 1'b1;
         if ((avs_read || avs_write) && avs_waitrequest
             && st == SIES_IDLE && !any_go) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer and processor registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= SIES_IDLE;
         cnt <= 3'h0;
         {ext_f, first_f, ics_int, nest_sched} <= 4'h0;
         {label, drt_addr, tmp, user_s} <= '0;
         dev <= 8'h00;
         {status, pc, sp, fq, fz} <= '0;
         {dbr, dlr, cbase, clim, xr} <= '0;
         {cbank, dbank, sbank} <= '0;
         tos_n <= 3'h0;
         for (int i = 0; i < TOS_DEPTH; i++)
            top_stack_cache[i] <= `SIES_RST_WORD;
         {ics_flag, sched_flag, ret_pend} <= 3'h0;
         mem_req <= '0;
         {int_ack, ext_ack, rst_cmd, fetch_done} <= 4'h0;
         rst_dev <= 8'h00;
         fetch_instr <= 16'h0000;
      end else if (ce) begin
         {int_ack, ext_ack, rst_cmd, fetch_done} <= 4'h0;
         // Software writes, only ever accepted while idle
         if (bus_wr) begin
            unique case (avs_address)
               `SIES_REG_CTRL: begin
                  ret_pend <= avs_writedata[`SIES_CTRL_RET_BIT];
                  if (avs_writedata[`SIES_CTRL_SCHED_BIT])
                     sched_flag <= 1'b1;
                  else if (avs_writedata[`SIES_CTRL_SCHED_CLR_BIT])
                     sched_flag <= 1'b0;
                  ics_flag <= avs_writedata[`SIES_CTRL_ICS_BIT];
               end
               `SIES_REG_STATUS: status <= avs_writedata[15:0];
               `SIES_REG_PC: pc <= avs_writedata[15:0];
               `SIES_REG_SP: sp <= avs_writedata[15:0];
               `SIES_REG_FRAME: fq <= avs_writedata[15:0];
               `SIES_REG_SLIMIT: fz <= avs_writedata[15:0];
               `SIES_REG_DBASE: dbr <= avs_writedata[15:0];
               `SIES_REG_DLIMIT: dlr <= avs_writedata[15:0];
               `SIES_REG_CBASE: cbase <= avs_writedata[15:0];
               `SIES_REG_CLIMIT: clim <= avs_writedata[15:0];
               `SIES_REG_CBANK: cbank <= avs_writedata[7:0];
               `SIES_REG_DBANK: dbank <= avs_writedata[7:0];
               `SIES_REG_SBANK: sbank <= avs_writedata[7:0];
               `SIES_REG_INDEX: xr <= avs_writedata[15:0];
               `SIES_REG_TOSN: tos_n <= avs_writedata[2:0];
               default: begin
                  if (avs_address >= `SIES_REG_TOS0 && avs_address
                      < `SIES_REG_TOS0 + 5'(TOS_DEPTH))
                     top_stack_cache[2'(avs_address - `SIES_REG_TOS0)]
                        <= avs_writedata[15:0];
               end
            endcase
         end
         // one access in flight, next step waits for ack
         if (st != SIES_IDLE && !mem_req.valid) begin
            mem_req <= next_acc;
         end else if (mem_req.valid && mem_ack) begin
            mem_req.valid <= 1'b0;
            unique case (st)
               SIES_FLUSH: begin
                  sp <= sp + 16'h0001;
                  cnt <= cnt + 3'h1;
                  if (cnt + 3'h1 == tos_n) begin
                     tos_n <= 3'h0;
                     cnt <= 3'h0;
                     st <= SIES_MARK;
                  end
               end
               SIES_MARK: begin
                  sp <= sp + 16'h0001;
                  cnt <= cnt + 3'h1;
                  if (cnt == 3'h0)
                     user_s <= sp;
                  // frame moves to new link word
                  if (cnt == `SIES_LINK_IDX)
                     fq <= sp + 16'h0001;
                  if (cnt == mark_len - 3'h1) begin
                     cnt <= 3'h0;
                     if (ext_f && !first_f) begin
                        st <= SIES_RDDBI;
                     end else if (first_f) begin
                        // interrupt stack is in bank 0
                        sbank <= 8'h00;
                        st <= SIES_LDQI;
                     end else begin
                        st <= SIES_RDCST;
                     end
                  end
               end
               SIES_LDQI: begin
                  fq <= mem_rdata;
                  st <= SIES_LDZI;
               end
               SIES_LDZI: begin
                  fz <= mem_rdata;
                  ics_flag <= 1'b1;
                  if (ext_f) begin
                     dlr <= `SIES_DL_ICS;
                     st <= SIES_RDQ4;
                  end else begin
                     sp <= fq + `SIES_RET_P_OFF;
                     st <= SIES_RDCST;
                  end
               end
               SIES_RDQ4: begin
                  tmp <= mem_rdata;
                  st <= SIES_WRQ6;
               end
               // relative pointer stored, first level only
               SIES_WRQ6: st <= SIES_RDDBI;
               SIES_RDDBI: begin
                  dbr <= mem_rdata;
                  if (first_f) begin
                     status <= `SIES_STAT_EXT;
                     dbank <= 8'h00;
                  end
                  st <= SIES_WRDEV;
               end
               SIES_WRDEV: begin
                  sp <= fq + `SIES_PARAM_OFF;
                  st <= first_f ? SIES_RDLBL : SIES_RDLBL;
               end
               SIES_RDLBL: begin
                  label <= mem_rdata;
                  st <= first_f ? SIES_RDCST : SIES_RDSTT;
               end
               SIES_RDCST: begin
                  cnt <= cnt + 3'h1;
                  unique case (cnt)
                     3'h0: cbank <= mem_rdata[7:0];
                     3'h1: cbase <= mem_rdata;
                     default: clim <= mem_rdata;
                  endcase
                  if (cnt == `SIES_CST_LAST) begin
                     cnt <= 3'h0;
                     if (!ext_f)
                        status <= `SIES_STAT_INT;
                     st <= SIES_RDSTT;
                  end
               end
               SIES_RDSTT: begin
                  pc <= cbase + mem_rdata;
                  if (ext_f && first_f)
                     status[7:0] <= label[7:0];
                  st <= SIES_FETCH;
               end
               SIES_FETCH: begin
                  fetch_instr <= mem_rdata;
                  fetch_done <= 1'b1;
                  st <= SIES_IDLE;
               end
               SIES_RTDEV: begin
                  rst_dev <= mem_rdata[7:0];
                  st <= SIES_RTLNK;
               end
               SIES_RTLNK: begin
                  tmp <= mem_rdata;
                  st <= SIES_RTP;
               end
               SIES_RTP: begin
                  pc <= cbase + mem_rdata;
                  sp <= fq - `SIES_USRDB_OFF;
                  fq <= fq - {1'b0, tmp[14:0]};
                  rst_cmd <= 1'b1;
                  st <= SIES_IDLE;
               end
               default: st <= SIES_IDLE;
            endcase
         end else if (st == SIES_IDLE && avs_waitrequest) begin
            // new entry only once idle, so preemption nests
            cnt <= 3'h0;
            if (go_int) begin
               int_ack <= 1'b1;
               ext_f <= 1'b0;
               ics_int <= int_ics;
               first_f <= int_ics;
               nest_sched <= 1'b0;
               label <= {int_stt, `SIES_INT_SEG};
               st <= (tos_n != 3'h0) ? SIES_FLUSH : SIES_MARK;
            end else if (go_ext) begin
               ext_ack <= 1'b1;
               ext_f <= 1'b1;
               ics_int <= 1'b0;
               dev <= ext_dev;
               drt_addr <= tbl_addr(DRT_BASE, ext_dev);
               first_f <= !(ics_flag || sched_flag);
               nest_sched <= sched_flag;
               sched_flag <= 1'b0;
               st <= (tos_n != 3'h0) ? SIES_FLUSH : SIES_MARK;
            end else if (go_ret) begin
               ret_pend <= 1'b0;
               st <= SIES_RTDEV;
            end
         end
      end
   end

endmodule

// ### bench/sies_properties.sv
// Port-level checks of the sequencer handshakes and entry order
`timescale 1ns/100ps
module sies_properties
   import sies_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire logic avs_waitrequest,
   input wire sies_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic int_req,
   input wire logic int_ack,
   input wire logic ext_ack,
   input wire logic rst_cmd,
   input wire logic fetch_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Bus answer lasts one cycle
   property p_ans;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans)
      else $error("bus answer too long");
   // Memory request held until acknowledged
   property p_hold;
      mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req);
   endproperty
   a_hold: assert property (p_hold)
      else $error("memory request changed early");
   // One access at a time: gap after each ack
   property p_gap;
      mem_req.valid && mem_ack |=> !mem_req.valid;
   endproperty
   a_gap: assert property (p_gap)
      else $error("no gap after memory ack");
   // Internal ack only for a request, never with external
   property p_int;
      int_ack |-> $past(int_req) && !ext_ack;
   endproperty
   a_int: assert property (p_int)
      else $error("internal ack without request");
   // External entry reaches the receiver in bounded time
   property p_ext_done;
      ext_ack |-> ##[4:600] fetch_done;
   endproperty
   a_ext_done: assert property (p_ext_done)
      else $error("external entry never fetched");
   // Internal entry reaches its handler in bounded time
   property p_int_done;
      int_ack |-> ##[4:600] fetch_done;
   endproperty
   a_int_done: assert property (p_int_done)
      else $error("internal entry never fetched");
   // No new entry after an external one before the receiver starts
   property p_once;
      ext_ack |=> (!ext_ack && !int_ack) until fetch_done;
   endproperty
   a_once: assert property (p_once)
      else $error("entry accepted mid-sequence");
   // Reset command is a single pulse
   property p_rst;
      rst_cmd |=> !rst_cmd [*2];
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset command repeated");
endmodule
bind sies_seq sies_properties i_sies_properties (.clk, .srst,
   .avs_waitrequest, .mem_req, .mem_ack, .int_req, .int_ack, .ext_ack,
   .rst_cmd, .fetch_done);

// ### bench/sies_mem_model.sv
// Memory partner answering promptly or slowly
`timescale 1ns/100ps
module sies_mem_model
   import sies_pkg::*;
(
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Memory port
   input wire sies_mem_req_t mem_req,
   output logic mem_ack = 1'h0,
   output logic [15:0] mem_rdata = 16'h0000
);
   logic [15:0] m [0:65535];
   logic [1:0] cnt = 2'h0;
   initial for (int i = 0; i < 65536; i++) m[i] = 16'h0000;
   // Data toggles when idle, so stale data never looks valid
   always @(posedge clk) begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) begin
         cnt <= cnt + 2'h1;
         if (!slow || cnt == 2'h2) begin
            mem_ack <= 1'h1;
            cnt <= 2'h0;
            if (mem_req.we)
               m[mem_req.addr] <= mem_req.wdata;
            else
               mem_rdata <= m[mem_req.addr];
         end
      end
   end
endmodule

// ### bench/tb_stack_interrupt_entry_sequencer.sv
// Self-checking bench for the interrupt entry sequencer
`timescale 1ns/100ps
`include "sies_regs.svh"
module tb_stack_interrupt_entry_sequencer
   import sies_pkg::*;
;
   logic clk = 1'h0, srst = 1'h1, ce = 1'h1, slow = 1'h0;
   logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, mem_ack;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
   logic int_req = 1'h0, int_ics = 1'h0, int_ack, ext_req = 1'h0;
   logic [7:0] int_stt = 8'h03, ext_dev = 8'h00, rst_dev;
   logic ext_ack, rst_cmd, fetch_done;
   logic [15:0] mem_rdata, fetch_instr;
   sies_mem_req_t mem_req;
   int n_errors = 0, checks = 0, cyc = 0;
   // Preload pairs {address, word}; rows {register, expected}
   logic [31:0] pre [15] = '{32'h0005_0100, 32'h0006_01F0,
      32'h00FC_0F00, 32'h0805_2000, 32'h0806_2100, 32'h20FD_0040,
      32'h2040_A5A5, 32'h0415_0202, 32'h0416_0600, 32'h0809_3000,
      32'h080A_3100, 32'h30FE_0010, 32'h3010_5A5A, 32'h0425_0202,
      32'h0426_0700};
   logic [36:0] rows [13] = '{{5'h01, 32'hC002}, {5'h02, 32'h3010},
      {5'h03, 32'h0103}, {5'h04, 32'h0100}, {5'h05, 32'h01F0},
      {5'h06, 32'h0600}, {5'h07, 32'hFFFF}, {5'h08, 32'h3000},
      {5'h09, 32'h3100}, {5'h0B, 32'h0}, {5'h0C, 32'h0},
      {5'h00, 32'h2}, {5'h1F, 32'h0}};
   sies_seq i_sies_seq (.clk, .srst, .ce, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .mem_req, .mem_ack, .mem_rdata, .int_req, .int_ics, .int_stt,
      .int_ack, .ext_req, .ext_dev, .ext_ack, .rst_cmd, .rst_dev,
      .fetch_done, .fetch_instr);
   sies_mem_model i_sies_mem_model (.clk, .slow, .mem_req, .mem_ack,
      .mem_rdata);
   always #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [31:0] mw(input logic [15:0] a);
      return {16'h0, i_sies_mem_model.m[a]};
   endfunction
   // Bus cycle held until the answer edge
   task automatic bus(input logic w, input logic [4:0] a,
         input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      rdv = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk);
   endtask
   // Raise a request, drop it at the ack, wait for the receiver
   // polled device number held with request, zero for internal ones
   task automatic irq(input logic x, input logic [7:0] d);
      int_req <= x;
      ext_req <= !x;
      ext_dev <= d;
      do @(posedge clk); while ((x ? int_ack : ext_ack) !== 1'h1);
      int_req <= 1'h0;
      ext_req <= 1'h0;
      do @(posedge clk); while (fetch_done !== 1'h1);
   endtask
   task automatic summarize;
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 15; i++)
         i_sies_mem_model.m[pre[i][31:16]] = pre[i][15:0];
      bus(1'h1, `SIES_REG_SP, 32'h1000);
      for (int k = 0; k < 2; k++) begin
         int_ics <= k[0];
         irq(1'h1, 8'h00);
         chk("instr", 32'hA5A5, {16'h0, fetch_instr});
         bus(1'h0, `SIES_REG_STATUS, 32'h0);
         chk("status", 32'h8001, rdv);
         bus(1'h0, `SIES_REG_CBASE, 32'h0);
         chk("cbase", 32'h2000, rdv);
      end
      srst <= 1'h1;
      @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      bus(1'h0, `SIES_REG_CTRL, 32'h0);
      chk("ctrl", 32'h0, rdv);
      bus(1'h1, `SIES_REG_SP, 32'h1000);
      bus(1'h1, `SIES_REG_DBASE, 32'h0F00);
      bus(1'h1, `SIES_REG_STATUS, 32'h4000);
      irq(1'h0, 8'h05);
      chk("instr", 32'h5A5A, {16'h0, fetch_instr});
      for (int i = 0; i < 13; i++) begin
         bus(1'h0, rows[i][36:32], 32'h0);
         chk("reg", rows[i][31:0], rdv);
      end
      chk("db save", 32'h0F00, mw(16'h1006));
      chk("s save", 32'h0100, mw(16'h00FA));
      chk("dev", 32'h5, mw(16'h0103));
      slow <= 1'h1;
      irq(1'h0, 8'h09);
      chk("link", 32'h7, mw(16'h0107));
      chk("db nest", 32'h0600, mw(16'h0109));
      chk("dev2", 32'h9, mw(16'h010A));
      chk("s keep", 32'h0100, mw(16'h00FA));
      bus(1'h1, `SIES_REG_CTRL, 32'h3);
      do @(posedge clk); while (rst_cmd !== 1'h1);
      chk("rst dev", 32'h9, {24'h0, rst_dev});
      bus(1'h0, `SIES_REG_FRAME, 32'h0);
      chk("frame", 32'h0100, rdv);
      // Scheduler interrupted, with one cached stack word to flush
      bus(1'h1, `SIES_REG_TOS0, 32'h1234);
      bus(1'h1, `SIES_REG_TOSN, 32'h1);
      bus(1'h1, `SIES_REG_CTRL, 32'h6);
      irq(1'h0, 8'h09);
      chk("flush", 32'h1234, mw(16'h0104));
      chk("disp link", 32'h8008, mw(16'h0108));
      bus(1'h0, `SIES_REG_CTRL, 32'h0);
      chk("sched clr", 32'h2, rdv);
      summarize();
   end
endmodule
